//--- hw/srpc_consts.svh
// Offsets, field positions and reset values of the soft reset and power capability bank.
// Assumes a 12-bit APB byte address; each register takes one aligned 32-bit word.
`ifndef SRPC_CONSTS_SVH
`define SRPC_CONSTS_SVH

// Printed offsets are register indices; byte address is four times the index
`define SRPC_GSR_INDEX 10'h006
`define SRPC_PCAP_INDEX 10'h008
`define SRPC_GSR_ADDR {`SRPC_GSR_INDEX, 2'h0}
`define SRPC_PCAP_ADDR {`SRPC_PCAP_INDEX, 2'h0}
`define SRPC_PCS_ADDR 12'h030
`define SRPC_ISR_ADDR 12'h040
`define SRPC_IMR_ADDR 12'h044

`define SRPC_GSR_BIT 0
`define SRPC_CAP_D3COLD_BIT 15
`define SRPC_CAP_D3HOT_BIT 14
`define SRPC_CAP_WAKE_D2_BIT 13
`define SRPC_CAP_WAKE_D1_BIT 12
`define SRPC_CAP_WAKE_D0_BIT 11
`define SRPC_CAP_STATE2_SUPPORTED_CFG_BIT 10
`define SRPC_CAP_STATE1_SUPPORTED_CFG_BIT 9
`define SRPC_CAP_BUS16_BIT 0
`define SRPC_CAP_RESET 16'h4000
`define SRPC_CAP_LOAD_MASK 16'h3601

// Positions inside the EEPROM configuration word
`define SRPC_CFG_WAKE_D2_BIT 13
`define SRPC_CFG_WAKE_D1_BIT 12
`define SRPC_CFG_STATE2_SUPPORTED_CFG_BIT 10
`define SRPC_CFG_STATE1_SUPPORTED_CFG_BIT 9
`define SRPC_CFG_BUS16_BIT 0

// Power control and status: state in 1:0, wake enable, sticky wake status
`define SRPC_PCS_STATE_LSB 0
`define SRPC_PCS_WAKE_EN_BIT 8
`define SRPC_PCS_WAKE_STS_BIT 15

`define SRPC_INT_WAKE_BIT 0
`define SRPC_INT_LOAD_BIT 1
`define SRPC_INT_WIDTH 2
`define SRPC_UNIT_COUNT 5

// The 8/16-bit host bus variant reports its width in capability bit 0
`define SRPC_NARROW_BUS_VARIANT 1'b1

`endif

//--- hw/srpc_pkg.sv
// Types shared by the soft reset and power capability bank.
// Assumes nothing of its surroundings.
package srpc_pkg;

   typedef enum logic [1:0] {
      SRPC_D0 = 2'b00,
      SRPC_D1 = 2'b01,
      SRPC_D2 = 2'b10,
      SRPC_D3_HOT = 2'b11
   } srpc_pstate_type;

endpackage : srpc_pkg

//--- hw/srpc_regs.sv
// Soft reset control and power capability registers behind an APB slave.
// Assumes mclk at 125 MHz, reset asynchronous active high, and an EEPROM
// loader on mclk pulsing eeprom_cfg_valid with configuration word 0x6.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "srpc_consts.svh"

module srpc_regs (
   input wire logic mclk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic eeprom_enable_pin,
   input wire logic [15:0] eeprom_cfg_word,
   input wire logic eeprom_cfg_valid,
   input wire logic wake_signal,
   output logic global_soft_reset,
   output logic phy_reset,
   output logic mac_reset,
   output logic queue_manager_reset,
   output logic dma_reset,
   output logic switch_reset,
   output logic wake_event_out_n,
   output logic irq
);

   logic gsr_reg;
   logic [15:0] cap_reg;
   logic [15:0] cap_next;
   srpc_pkg::srpc_pstate_type pstate_reg;
   logic wake_en_reg;
   logic wake_sts_reg;
   logic wake_sts_next;
   logic [`SRPC_INT_WIDTH-1:0] isr_reg;
   logic [`SRPC_INT_WIDTH-1:0] isr_next;
   logic [`SRPC_INT_WIDTH-1:0] imr_reg;
   logic [`SRPC_INT_WIDTH-1:0] int_events;
   logic [`SRPC_UNIT_COUNT-1:0] unit_rst_reg;
   logic en_meta_reg;
   logic en_sync_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic wake_out_n_reg;
   logic irq_reg;
   logic wake_fire;

   // Bus decode
   wire setup_phase = psel & ~penable;
   wire access_done = psel & penable & pready_reg;
   wire wr_done = access_done & pwrite;
   wire hit_gsr = (paddr == `SRPC_GSR_ADDR);
   wire hit_pcap = (paddr == `SRPC_PCAP_ADDR);
   wire hit_pcs = (paddr == `SRPC_PCS_ADDR);
   wire hit_isr = (paddr == `SRPC_ISR_ADDR);
   wire hit_imr = (paddr == `SRPC_IMR_ADDR);
   wire hit_any = hit_gsr | hit_pcap | hit_pcs | hit_isr | hit_imr;
   wire wr_gsr = wr_done & hit_gsr;
   wire wr_pcs = wr_done & hit_pcs;
   wire wr_isr = wr_done & hit_isr;
   wire wr_imr = wr_done & hit_imr;

   // Read data; unused and reserved bits read as zero
   wire [15:0] pcs_view = {wake_sts_reg, 6'h00, wake_en_reg, 6'h00, pstate_reg};
   wire [15:0] rd16 = hit_gsr ? {15'h0000, gsr_reg} :
                      hit_pcap ? cap_reg :
                      hit_pcs ? pcs_view :
                      hit_isr ? {14'h0000, isr_reg} :
                      hit_imr ? {14'h0000, imr_reg} : 16'h0000;
   wire [31:0] rd_mux = {16'h0000, rd16};

   // APB answer: one cycle after the setup phase
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= setup_phase;
         pslverr_reg <= setup_phase & ~hit_any;
         prdata_reg <= (setup_phase & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         gsr_reg <= 1'b0;
      end else if (wr_gsr) begin
         gsr_reg <= pwdata[`SRPC_GSR_BIT];
      end
   end

   // per unit resets, bus interface left alone
   genvar u;
   generate
      for (u = 0; u < `SRPC_UNIT_COUNT; u = u + 1) begin : g_unit
         always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
               unit_rst_reg[u] <= 1'b0;
            end else begin
               unit_rst_reg[u] <= gsr_reg;
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         en_meta_reg <= 1'b0;
         en_sync_reg <= 1'b0;
      end else begin
         en_meta_reg <= eeprom_enable_pin;
         en_sync_reg <= en_meta_reg;
      end
   end

   always_comb begin
      cap_next = cap_reg;
      if (!en_sync_reg) begin
         cap_next = `SRPC_CAP_RESET;
      end else if (eeprom_cfg_valid) begin
         cap_next[`SRPC_CAP_WAKE_D2_BIT] = eeprom_cfg_word[`SRPC_CFG_WAKE_D2_BIT];
         cap_next[`SRPC_CAP_WAKE_D1_BIT] = eeprom_cfg_word[`SRPC_CFG_WAKE_D1_BIT];
         cap_next[`SRPC_CAP_STATE2_SUPPORTED_CFG_BIT] = eeprom_cfg_word[`SRPC_CFG_STATE2_SUPPORTED_CFG_BIT];
         cap_next[`SRPC_CAP_STATE1_SUPPORTED_CFG_BIT] = eeprom_cfg_word[`SRPC_CFG_STATE1_SUPPORTED_CFG_BIT];
         cap_next[`SRPC_CAP_BUS16_BIT] =
            eeprom_cfg_word[`SRPC_CFG_BUS16_BIT] & `SRPC_NARROW_BUS_VARIANT;
      end
      cap_next[`SRPC_CAP_D3COLD_BIT] = 1'b0;
      cap_next[`SRPC_CAP_D3HOT_BIT] = 1'b1;
      cap_next[`SRPC_CAP_WAKE_D0_BIT] = 1'b0;
      cap_next[8:1] = 8'h00;
   end

   // no bus write reaches this register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         cap_reg <= `SRPC_CAP_RESET;
      end else begin
         cap_reg <= cap_next;
      end
   end

   // Power control: state and wake enable
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pstate_reg <= srpc_pkg::SRPC_D0;
         wake_en_reg <= 1'b0;
      end else if (wr_pcs) begin
         pstate_reg <= srpc_pkg::srpc_pstate_type'(pwdata[1:0]);
         wake_en_reg <= pwdata[`SRPC_PCS_WAKE_EN_BIT];
      end
   end

   srpc_wake_gate u_wake_gate (
      .pstate(pstate_reg),
      .wake_en(wake_en_reg),
      .wake_d2_cap(cap_reg[`SRPC_CAP_WAKE_D2_BIT]),
      .wake_d1_cap(cap_reg[`SRPC_CAP_WAKE_D1_BIT]),
      .wake_in(wake_signal),
      .fire(wake_fire)
   );

   // Sticky wake status, set wins over write-one-clear
   assign wake_sts_next = wake_fire |
      (wake_sts_reg & ~(wr_pcs & pwdata[`SRPC_PCS_WAKE_STS_BIT]));

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         wake_sts_reg <= 1'b0;
         wake_out_n_reg <= 1'b1;
      end else begin
         wake_sts_reg <= wake_sts_next;
         wake_out_n_reg <= ~wake_sts_next;
      end
   end

   // Interrupt status, mask and level output
   assign int_events = {eeprom_cfg_valid & en_sync_reg, wake_fire};
   assign isr_next = int_events |
      (isr_reg & ~(wr_isr ? pwdata[`SRPC_INT_WIDTH-1:0] : 2'h0));

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         isr_reg <= 2'h0;
         imr_reg <= 2'h0;
         irq_reg <= 1'b0;
      end else begin
         isr_reg <= isr_next;
         irq_reg <= |(isr_next & (wr_imr ? pwdata[`SRPC_INT_WIDTH-1:0] : imr_reg));
         if (wr_imr) begin
            imr_reg <= pwdata[`SRPC_INT_WIDTH-1:0];
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign global_soft_reset = gsr_reg;
   assign phy_reset = unit_rst_reg[0];
   assign mac_reset = unit_rst_reg[1];
   assign queue_manager_reset = unit_rst_reg[2];
   assign dma_reset = unit_rst_reg[3];
   assign switch_reset = unit_rst_reg[4];
   assign wake_event_out_n = wake_out_n_reg;
   assign irq = irq_reg;

   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   sequence s_read_setup(logic hit);
      psel && !penable && !pwrite && hit;
   endsequence

   sequence s_wake_cause(logic [1:0] st, int bitpos);
      wake_signal && wake_en_reg && pstate_reg == st && cap_reg[bitpos];
   endsequence

   a_gsr_write_back: assert property (
      wr_gsr |=> gsr_reg == $past(pwdata[0]))
      else $error("soft reset bit did not take written value");

   a_gsr_read_back: assert property (
      s_read_setup(hit_gsr) |=> prdata[0] == gsr_reg && pready)
      else $error("soft reset bit read back wrong");

   a_unit_reset_follow: assert property (
      gsr_reg |=> phy_reset && mac_reset && queue_manager_reset && dma_reset && switch_reset)
      else $error("unit reset not asserted under soft reset");

   a_unit_reset_release: assert property (
      !gsr_reg |=> !phy_reset && !mac_reset && !queue_manager_reset && !dma_reset && !switch_reset)
      else $error("unit reset stuck after soft reset release");

   a_cap_no_write: assert property (
      wr_done && hit_pcap && !eeprom_cfg_valid && en_sync_reg |=> $stable(cap_reg))
      else $error("capability register changed on a bus write");

   a_cap_fixed_read: assert property (
      s_read_setup(hit_pcap) |=> prdata[15] == 1'b0 && prdata[14] == 1'b1 && prdata[11] == 1'b0)
      else $error("fixed capability bits read wrong");

   a_wake_d2_fire: assert property (
      s_wake_cause(2'b10, 13) |=> !wake_event_out_n && isr_reg[0])
      else $error("wake event missing in D2");

   a_wake_d1_fire: assert property (
      s_wake_cause(2'b01, 12) |=> !wake_event_out_n)
      else $error("wake event missing in D1");

   a_wake_d2_block: assert property (
      wake_signal && pstate_reg == srpc_pkg::SRPC_D2 && !cap_reg[13] && wake_event_out_n
      |=> wake_event_out_n)
      else $error("wake event raised in D2 without capability");

   a_wake_d0_block: assert property (
      pstate_reg == srpc_pkg::SRPC_D0 && wake_event_out_n && !(wr_pcs && pwdata[1:0] != 2'b00)
      |=> wake_event_out_n [*2])
      else $error("wake event raised in D0");

   a_cfg_load_wake: assert property (
      eeprom_cfg_valid && en_sync_reg |=>
      cap_reg[13] == $past(eeprom_cfg_word[13]) && cap_reg[12] == $past(eeprom_cfg_word[12]))
      else $error("wake capability not loaded from EEPROM");

   a_cfg_load_sup: assert property (
      eeprom_cfg_valid && en_sync_reg |=>
      cap_reg[10] == $past(eeprom_cfg_word[10]) && cap_reg[9] == $past(eeprom_cfg_word[9]))
      else $error("state support not loaded from EEPROM");

   a_no_eeprom_zero: assert property (
      !en_sync_reg |=> cap_reg == 16'h4000)
      else $error("loadable capability bits set without EEPROM");

   a_bus_width_load: assert property (
      eeprom_cfg_valid && en_sync_reg |=> cap_reg[0] == $past(eeprom_cfg_word[0]))
      else $error("bus width bit not loaded");

   a_reserved_zero: assert property (
      s_read_setup(hit_gsr || hit_pcap) |=> prdata[31:16] == 16'h0000 && prdata[8:1] == 8'h00)
      else $error("reserved bits read nonzero");

   a_irq_level: assert property (
      (isr_reg & imr_reg) != 2'h0 |-> irq)
      else $error("interrupt low with unmasked status set");

   a_cap_read_value: assert property (
      s_read_setup(hit_pcap) |=> prdata[15:0] == $past(cap_reg))
      else $error("capability read differs from register");

   a_state1_supported_cfg_load: assert property (
      eeprom_cfg_valid && en_sync_reg |=> cap_reg[9] == $past(eeprom_cfg_word[9]))
      else $error("D1 support bit not loaded from EEPROM");

   a_bus_width_noeep: assert property (
      !en_sync_reg |=> !cap_reg[0])
      else $error("bus width bit set without EEPROM");

   a_wake_no_enable: assert property (
      wake_signal && !wake_en_reg && wake_event_out_n |=> wake_event_out_n)
      else $error("wake event raised with wake enable clear");

   a_pready_pulse: assert property (
      pready |=> !pready)
      else $error("pready held longer than one cycle");

   a_unmapped_error: assert property (
      psel && !penable && !hit_any |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access without error response");

endmodule : srpc_regs

//--- hw/srpc_wake_gate.sv
// Decides whether a wake-up signal may raise the wake event in the current power state.
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/1ps

module srpc_wake_gate (
   input wire srpc_pkg::srpc_pstate_type pstate,
   input wire logic wake_en,
   input wire logic wake_d2_cap,
   input wire logic wake_d1_cap,
   input wire logic wake_in,
   output logic fire
);

   logic state_allows;

   always_comb begin
      case (pstate)
         srpc_pkg::SRPC_D0: state_allows = 1'b0;
         srpc_pkg::SRPC_D1: state_allows = wake_d1_cap;
         srpc_pkg::SRPC_D2: state_allows = wake_d2_cap;
         srpc_pkg::SRPC_D3_HOT: state_allows = 1'b1;
         default: state_allows = 1'b0;
      endcase
   end

   assign fire = wake_in & wake_en & state_allows;

endmodule : srpc_wake_gate

//--- tb/srpc_regs_test.sv
// Self-checking bench for the soft reset and power capability register bank.
// Assumes srpc_regs with its APB slave answering one cycle after setup.
`timescale 1ns/1ps
`include "srpc_consts.svh"

module srpc_regs_test;
   typedef struct packed {
      logic [11:0] a;
      logic [31:0] wd;
      logic [31:0] rd;
      logic er;
   } srpc_row_type;

   logic mclk, reset, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic pready, pslverr, rerr;
   logic eeprom_enable_pin, eeprom_cfg_valid, wake_signal;
   logic [15:0] eeprom_cfg_word;
   logic global_soft_reset, phy_reset, mac_reset, queue_manager_reset, dma_reset;
   logic switch_reset, wake_event_out_n, irq, exp_wake;
   int failures = 0;
   int num_checks = 0;
   // Write, then read back: address, write data, read data, error
   srpc_row_type rows [6] = '{
      '{`SRPC_GSR_ADDR, 32'hffffffff, 32'h00000001, 1'b0},
      '{`SRPC_GSR_ADDR, 32'h00000000, 32'h00000000, 1'b0},
      '{`SRPC_PCAP_ADDR, 32'hffffffff, 32'h00004000, 1'b0},
      '{12'h100, 32'hffffffff, 32'h00000000, 1'b1},
      '{`SRPC_IMR_ADDR, 32'h00000003, 32'h00000003, 1'b0},
      '{`SRPC_PCS_ADDR, 32'h00000102, 32'h00000102, 1'b0}};

   srpc_regs srpc_regs_inst (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .eeprom_enable_pin(eeprom_enable_pin),
      .eeprom_cfg_word(eeprom_cfg_word), .eeprom_cfg_valid(eeprom_cfg_valid),
      .wake_signal(wake_signal), .global_soft_reset(global_soft_reset),
      .phy_reset(phy_reset), .mac_reset(mac_reset),
      .queue_manager_reset(queue_manager_reset), .dma_reset(dma_reset),
      .switch_reset(switch_reset), .wake_event_out_n(wake_event_out_n), .irq(irq));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task test_done;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         chk("pready", 32'h1, {31'h0, pready});
         test_done();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(name, exp, rdat);
   endtask : rdchk

   task automatic load(input logic [15:0] w);
      @(posedge mclk);
      eeprom_cfg_word <= w;
      eeprom_cfg_valid <= 1'b1;
      @(posedge mclk);
      eeprom_cfg_valid <= 1'b0;
   endtask : load

   task automatic pulse_wake;
      @(posedge mclk);
      wake_signal <= 1'b1;
      @(posedge mclk);
      wake_signal <= 1'b0;
      @(posedge mclk);
   endtask : pulse_wake

   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      eeprom_enable_pin = 1'b0;
      eeprom_cfg_word = 16'h0000;
      eeprom_cfg_valid = 1'b0;
      wake_signal = 1'b0;
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      chk("wake_n", 32'h1, {31'h0, wake_event_out_n});
      chk("soft", 32'h0, {31'h0, global_soft_reset});
      rdchk("gsr", `SRPC_GSR_ADDR, 32'h0);
      rdchk("caps", `SRPC_PCAP_ADDR, 32'h4000);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].wd);
         chk("werr", {31'h0, rows[i].er}, {31'h0, rerr});
         rdchk("rdback", rows[i].a, rows[i].rd);
         chk("rerr", {31'h0, rows[i].er}, {31'h0, rerr});
      end
      apb(1'b0, `SRPC_PCAP_ADDR, 32'h0);
      @(posedge mclk);
      chk("pready_low", 32'h0, {31'h0, pready});
      chk("prdata_idle", 32'h0, prdata);
      apb(1'b1, `SRPC_GSR_ADDR, 32'h1);
      @(posedge mclk);
      chk("soft", 32'h1, {31'h0, global_soft_reset});
      @(posedge mclk);
      chk("units", 32'h1f, {27'h0, phy_reset, mac_reset, queue_manager_reset, dma_reset,
         switch_reset});
      rdchk("mask_kept", `SRPC_IMR_ADDR, 32'h3);
      apb(1'b1, `SRPC_GSR_ADDR, 32'h0);
      repeat (2) @(posedge mclk);
      chk("units", 32'h0, {27'h0, phy_reset, mac_reset, queue_manager_reset, dma_reset,
         switch_reset});
      load(16'hffff);
      rdchk("caps_noeep", `SRPC_PCAP_ADDR, 32'h4000);
      eeprom_enable_pin <= 1'b1;
      repeat (3) @(posedge mclk);
      load(16'hffff);
      repeat (2) @(posedge mclk);
      chk("irq_load", 32'h1, {31'h0, irq});
      rdchk("caps_all", `SRPC_PCAP_ADDR, 32'h7601);
      apb(1'b1, `SRPC_PCAP_ADDR, 32'h0);
      chk("cap_werr", 32'h0, {31'h0, rerr});
      rdchk("caps_ro", `SRPC_PCAP_ADDR, 32'h7601);
      apb(1'b1, `SRPC_ISR_ADDR, 32'h2);
      repeat (2) @(posedge mclk);
      chk("irq_clr", 32'h0, {31'h0, irq});
      for (int c = 0; c < 2; c++) begin
         load(c == 0 ? 16'h0000 : 16'h3000);
         apb(1'b1, `SRPC_ISR_ADDR, 32'h3);
         for (int s = 0; s < 4; s++) begin
            apb(1'b1, `SRPC_PCS_ADDR, 32'h100 | s);
            pulse_wake();
            exp_wake = (s == 3) || (s != 0 && c == 1);
            chk("wake_n", {31'h0, ~exp_wake}, {31'h0, wake_event_out_n});
            @(posedge mclk);
            chk("irq_wake", {31'h0, exp_wake}, {31'h0, irq});
            apb(1'b1, `SRPC_PCS_ADDR, 32'h8100 | s);
            apb(1'b1, `SRPC_ISR_ADDR, 32'h1);
            @(posedge mclk);
            chk("wake_clr", 32'h1, {31'h0, wake_event_out_n});
         end
      end
      apb(1'b1, `SRPC_PCS_ADDR, 32'h3);
      pulse_wake();
      chk("wake_noen", 32'h1, {31'h0, wake_event_out_n});
      apb(1'b1, `SRPC_IMR_ADDR, 32'h0);
      apb(1'b1, `SRPC_PCS_ADDR, 32'h103);
      pulse_wake();
      repeat (2) @(posedge mclk);
      chk("irq_mask", 32'h0, {31'h0, irq});
      rdchk("isr_masked", `SRPC_ISR_ADDR, 32'h1);
      eeprom_enable_pin <= 1'b0;
      repeat (4) @(posedge mclk);
      rdchk("caps_off", `SRPC_PCAP_ADDR, 32'h4000);
      apb(1'b1, `SRPC_GSR_ADDR, 32'h1);
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      chk("soft_rst", 32'h0, {31'h0, global_soft_reset});
      rdchk("gsr_rst", `SRPC_GSR_ADDR, 32'h0);
      test_done();
   end
endmodule : srpc_regs_test
